// ### rtl/dram_host_consts.vh
// constants for the dram address controller host sequencer
`ifndef DRAM_HOST_CONSTS_VH
`define DRAM_HOST_CONSTS_VH

`define CLK_PERIOD_NS 20
`define GUARD_NS 20
`define ALS_PULSE_NS 30
`define ROW_LOW_MODE5_NS 200
`define ROW_LOW_MODE6_NS 180
`define CAS_EXT_NS 60
`define REFRESH_LOW_NS 100
`define REFRESH_PERIOD_NS 16000

`define REG_MODE 4'h0
`define REG_CMD 4'h4
`define REG_STATUS 4'h8
`define REG_EOC 4'hc

`define MODE_EXT_REFRESH 3'h0
`define MODE_AUTO_REFRESH 3'h2
`define MODE_HIDDEN 3'h5
`define MODE_FAST 3'h6
`define MODE_SET_EOC 3'h7
`define MODE_RESET 3'h5

`define CMD_BANK_LSB 0
`define CMD_EXTEND_BIT 2
`define CMD_REFRESH_BIT 3
`define CMD_SET_EOC_BIT 4

`define EOC_RESET 10'h07f
`define EOC_255 10'h0ff
`define EOC_511 10'h1ff

`endif

// ### rtl/dram_host.v
// host sequencer driving the dram address and strobe controller pins
// Behaviour
// R1 - the device latches the two bank bits on the address latch strobe and enables row strobe 0 to 3 for 00 to 11.
// R2 - in hidden refresh mode a row request too soon after select may be taken by the device as a hidden refresh.
// R3 - in hidden refresh mode the host keeps the row request high for the guard interval after select falls.
// R4 - when ending an access in hidden refresh mode the host keeps select low for the guard after the row request rises.
// R5 - in fast mode the device sequences row strobe, address switch and column strobe with a 20 ns row hold.
// R6 - in fast mode the device ignores the row/column select pin and takes the column request purely as such.
// R7 - in fast mode the device holds its column strobe low while the column request is low, ending it when it rises.
// R8 - in fast mode the host holds the column request high when no extended column strobe is wanted.
// R9 - fast mode has no internal refresh request, so refresh needs mode 0 or mode 2; the host switches the mode pins to mode 0.
// R10 - in end-of-count mode the latched bank bits set the end-of-count to 127 when equal, 255 for 01, 511 for 10.
// R11 - the selected end-of-count stays until a later end-of-count load.
// R12 - at power-up the end-of-count is 127, as if both bank bits were ones.
// R13 - in hidden refresh mode a rising refresh period clock sets the device's refresh request flag.
// R14 - during a hidden refresh the device puts the refresh counter out and all row strobes follow the row request.
// R15 - in a normal access only the decoded bank's row strobe is low, and only while the row request is low.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "dram_host_consts.vh"

module dram_host #(
  parameter REFRESH_PERIOD_NS = `REFRESH_PERIOD_NS // refresh period clock cycle time
) (
  input wire clk_sys_i, // 50 MHz system clock
  input wire rstn_i, // async reset, active low
  input wire [3:0] addr_i, // register byte address
  input wire [31:0] wdata_i, // register write data
  input wire wr_i, // write strobe
  input wire rd_i, // read strobe
  output reg [31:0] rdata_o, // read data, cycle after rd_i
  input wire refresh_req_n_i, // device forced refresh request pin, low active
  output reg [2:0] mode_o, // device mode select pins
  output reg chip_select_n_o, // device select, low active
  output reg address_latch_strobe_o, // address latch strobe, latches on fall
  output reg bank_select_high_o, // bank select high bit
  output reg bank_select_low_o, // bank select low bit
  output reg row_strobe_request_in_n_o, // row strobe request, low active
  output reg column_strobe_request_in_n_o, // column strobe request, low active
  output reg refresh_period_clock_o // row/column select pin, refresh clock in hidden mode
);

  localparam GUARD_CYC = (`GUARD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam ALS_CYC = (`ALS_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam ROW5_CYC = (`ROW_LOW_MODE5_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam ROW6_CYC = (`ROW_LOW_MODE6_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam CASX_CYC = (`CAS_EXT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam RFL_CYC = (`REFRESH_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam RFP_HALF = REFRESH_PERIOD_NS / `CLK_PERIOD_NS / 2;

  localparam S_IDLE = 7'b000_0001;
  localparam S_LATCH = 7'b000_0010;
  localparam S_GUARD = 7'b000_0100;
  localparam S_ROW = 7'b000_1000;
  localparam S_CASX = 7'b001_0000;
  localparam S_HOLD = 7'b010_0000;
  localparam S_RFSH = 7'b100_0000;

  reg rst_s1_reg;
  reg rstn_reg;
  reg rf_s1_reg;
  reg rf_s2_reg;
  reg rf_s3_reg;
  reg rf_req_reg;
  reg [6:0] state_reg;
  reg [6:0] state_next;
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg [15:0] rfp_cnt_reg;
  reg [2:0] mode_reg;
  reg [1:0] bank_reg;
  reg extend_reg;
  reg eoc_op_reg;
  reg [9:0] eoc_reg;
  reg [15:0] access_cnt_reg;
  reg [15:0] refresh_cnt_reg;
  reg cmd_go;
  reg cmd_rfsh;
  wire busy;
  wire [15:0] row_cyc;

  always @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_s1_reg <= 1'b0;
      rstn_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rstn_reg <= rst_s1_reg;
    end
  end

  // three stage input, a change counts when stages two and three agree
  always @(posedge clk_sys_i or negedge rstn_reg)
  begin
    if (!rstn_reg)
    begin
      rf_s1_reg <= 1'b1;
      rf_s2_reg <= 1'b1;
      rf_s3_reg <= 1'b1;
      rf_req_reg <= 1'b0;
    end
    else
    begin
      rf_s1_reg <= refresh_req_n_i;
      rf_s2_reg <= rf_s1_reg;
      rf_s3_reg <= rf_s2_reg;
      if (rf_s2_reg == rf_s3_reg)
        rf_req_reg <= ~rf_s3_reg;
    end
  end

  assign busy = (state_reg != S_IDLE);
  assign row_cyc = (mode_reg == `MODE_FAST) ? ROW6_CYC[15:0] : ROW5_CYC[15:0];

  // register port, commands are taken only while idle
  always @*
  begin
    cmd_go = wr_i && (addr_i == `REG_CMD) && !busy && !wdata_i[`CMD_REFRESH_BIT];
    cmd_rfsh = wr_i && (addr_i == `REG_CMD) && !busy && wdata_i[`CMD_REFRESH_BIT];
  end

  always @(posedge clk_sys_i or negedge rstn_reg)
  begin
    if (!rstn_reg)
    begin
      mode_reg <= `MODE_RESET;
      bank_reg <= 2'h0;
      extend_reg <= 1'b0;
      eoc_op_reg <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end
    else
    begin
      if (wr_i && (addr_i == `REG_MODE) && !busy)
        mode_reg <= wdata_i[2:0];
      if (cmd_go)
      begin
        bank_reg <= wdata_i[`CMD_BANK_LSB+1:`CMD_BANK_LSB];
        extend_reg <= wdata_i[`CMD_EXTEND_BIT] && (mode_reg == `MODE_FAST);
        eoc_op_reg <= wdata_i[`CMD_SET_EOC_BIT];
      end
      rdata_o <= 32'h0000_0000;
      if (rd_i)
      begin
        case (addr_i)
          `REG_MODE: rdata_o <= {29'h0000_0000, mode_reg};
          `REG_CMD: rdata_o <= {27'h0000_000, eoc_op_reg, 1'b0, extend_reg, bank_reg};
          `REG_STATUS: rdata_o <= {refresh_cnt_reg, access_cnt_reg[12:0], refresh_period_clock_o, rf_req_reg, busy};
          `REG_EOC: rdata_o <= {22'h00_0000, eoc_reg};
          default: rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // sequencer
  always @*
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (cmd_rfsh)
        begin
          state_next = S_RFSH;
          cnt_next = RFL_CYC[15:0];
        end
        else if (cmd_go)
        begin
          state_next = S_LATCH;
          cnt_next = ALS_CYC[15:0];
        end
      end
      S_LATCH:
      begin
        if (cnt_reg == 16'h0001)
        begin
          state_next = eoc_op_reg ? S_IDLE : S_GUARD;
          cnt_next = GUARD_CYC[15:0];
        end
        else
          cnt_next = cnt_reg - 16'h0001;
      end
      S_GUARD: // see R3
      begin
        if (cnt_reg == 16'h0001)
        begin
          state_next = S_ROW;
          cnt_next = row_cyc;
        end
        else
          cnt_next = cnt_reg - 16'h0001;
      end
      S_ROW:
      begin
        if (cnt_reg == 16'h0001)
        begin
          state_next = extend_reg ? S_CASX : S_HOLD;
          cnt_next = extend_reg ? CASX_CYC[15:0] : GUARD_CYC[15:0];
        end
        else
          cnt_next = cnt_reg - 16'h0001;
      end
      S_CASX: // see R7
      begin
        if (cnt_reg == 16'h0001)
        begin
          state_next = S_HOLD;
          cnt_next = GUARD_CYC[15:0];
        end
        else
          cnt_next = cnt_reg - 16'h0001;
      end
      S_HOLD: // see R4
      begin
        if (cnt_reg == 16'h0001)
        begin
          state_next = S_IDLE;
          cnt_next = 16'h0000;
        end
        else
          cnt_next = cnt_reg - 16'h0001;
      end
      S_RFSH: // see R9
      begin
        if (cnt_reg == 16'h0001)
        begin
          state_next = S_HOLD;
          cnt_next = GUARD_CYC[15:0];
        end
        else
          cnt_next = cnt_reg - 16'h0001;
      end
      default:
      begin
        state_next = S_IDLE;
        cnt_next = 16'h0000;
      end
    endcase
  end

  always @(posedge clk_sys_i or negedge rstn_reg)
  begin
    if (!rstn_reg)
    begin
      state_reg <= S_IDLE;
      cnt_reg <= 16'h0000;
      access_cnt_reg <= 16'h0000;
      refresh_cnt_reg <= 16'h0000;
      eoc_reg <= `EOC_RESET; // see R12
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if ((state_reg == S_HOLD) && (cnt_reg == 16'h0001))
        access_cnt_reg <= access_cnt_reg + 16'h0001;
      if ((state_reg == S_RFSH) && (cnt_reg == 16'h0001))
        refresh_cnt_reg <= refresh_cnt_reg + 16'h0001;
      // shadow of the device end-of-count, changed only by a load
      if ((state_reg == S_LATCH) && (cnt_reg == 16'h0001) && eoc_op_reg && (mode_reg == `MODE_SET_EOC)) // see R10, R11
      begin
        if (bank_reg == 2'h1)
          eoc_reg <= `EOC_255;
        else if (bank_reg == 2'h2)
          eoc_reg <= `EOC_511;
        else
          eoc_reg <= `EOC_RESET;
      end
    end
  end

  // refresh period clock on the row/column select pin, free running in hidden refresh mode only, held low otherwise
  always @(posedge clk_sys_i or negedge rstn_reg)
  begin
    if (!rstn_reg)
    begin
      rfp_cnt_reg <= 16'h0000;
      refresh_period_clock_o <= 1'b0;
    end
    else if (mode_reg == `MODE_HIDDEN) // see R13
    begin
      if (rfp_cnt_reg >= RFP_HALF[15:0] - 16'h0001)
      begin
        rfp_cnt_reg <= 16'h0000;
        refresh_period_clock_o <= ~refresh_period_clock_o;
      end
      else
        rfp_cnt_reg <= rfp_cnt_reg + 16'h0001;
    end
    else
    begin
      rfp_cnt_reg <= 16'h0000;
      refresh_period_clock_o <= 1'b0; // see R6
    end
  end

  // pin drive
  always @(posedge clk_sys_i or negedge rstn_reg)
  begin
    if (!rstn_reg)
    begin
      mode_o <= `MODE_RESET;
      chip_select_n_o <= 1'b1;
      address_latch_strobe_o <= 1'b0;
      bank_select_high_o <= 1'b1;
      bank_select_low_o <= 1'b1;
      row_strobe_request_in_n_o <= 1'b1;
      column_strobe_request_in_n_o <= 1'b1;
    end
    else
    begin
      mode_o <= (state_next == S_RFSH) ? `MODE_EXT_REFRESH : mode_reg; // see R9
      chip_select_n_o <= !((state_next == S_LATCH) || (state_next == S_GUARD) || (state_next == S_ROW)
                           || (state_next == S_CASX) || (state_next == S_HOLD));
      address_latch_strobe_o <= (state_next == S_LATCH); // see R1
      if (state_reg == S_IDLE && cmd_go)
      begin
        bank_select_high_o <= wdata_i[`CMD_BANK_LSB+1];
        bank_select_low_o <= wdata_i[`CMD_BANK_LSB];
      end
      row_strobe_request_in_n_o <= !((state_next == S_ROW) || (state_next == S_RFSH)); // see R2, R14, R15
      column_strobe_request_in_n_o <= !(extend_reg && ((state_next == S_ROW) || (state_next == S_CASX))); // see R5, R8
    end
  end

endmodule // dram_host

// ### test/dram_host_chk.sv
// assertions on the host sequencer pins
`timescale 1ns/1ns
module dram_host_chk (
  input wire clk_sys_i, // clock
  input wire rstn_i, // reset, low active
  input wire [2:0] mode_o, // mode pins
  input wire chip_select_n_o, // device select
  input wire address_latch_strobe_o, // latch strobe
  input wire row_strobe_request_in_n_o, // row request
  input wire column_strobe_request_in_n_o, // column request
  input wire refresh_period_clock_o // refresh clock
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  guard_after_select_a: assert property (
    $fell(chip_select_n_o) && mode_o == 3'h5 |-> row_strobe_request_in_n_o [*3])
    else $error("row request fell inside the select guard");
  hold_after_row_a: assert property (
    $rose(row_strobe_request_in_n_o) && !$past(chip_select_n_o) |-> !chip_select_n_o)
    else $error("select released with the row request");
  column_idle_high_a: assert property (
    mode_o != 3'h6 |-> column_strobe_request_in_n_o)
    else $error("column request low outside fast mode");
  refresh_by_mode_a: assert property (
    !row_strobe_request_in_n_o && chip_select_n_o |-> mode_o == 3'h0 || mode_o == 3'h2)
    else $error("refresh row pulse outside a refresh mode");
  refresh_clock_quiet_a: assert property (
    mode_o != 3'h5 && $past(mode_o) != 3'h5 |-> !refresh_period_clock_o)
    else $error("refresh clock runs outside hidden refresh mode");
  latch_pulse_a: assert property (
    $rose(address_latch_strobe_o) |-> (address_latch_strobe_o && !chip_select_n_o) [*2] ##1 !address_latch_strobe_o)
    else $error("latch strobe pulse of wrong length");
endmodule // dram_host_chk
bind dram_host dram_host_chk i_dram_host_chk (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .mode_o(mode_o), .chip_select_n_o(chip_select_n_o),
  .address_latch_strobe_o(address_latch_strobe_o), .row_strobe_request_in_n_o(row_strobe_request_in_n_o),
  .column_strobe_request_in_n_o(column_strobe_request_in_n_o), .refresh_period_clock_o(refresh_period_clock_o)
);

// ### test/dram_dev_model.sv
// behavioural model of the dram address and strobe controller
`timescale 1ns/1ns
module dram_dev_model (
  input wire [2:0] mode_i, // mode pins
  input wire cs_n_i, // device select
  input wire als_i, // address latch strobe
  input wire bank_hi_i, // bank select high
  input wire bank_lo_i, // bank select low
  input wire row_n_i, // row strobe request
  input wire col_n_i, // column strobe request
  input wire rfclk_i, // refresh period clock
  output reg req_n_o, // forced refresh request
  output reg [3:0] ras_n_o, // row strobes
  output wire cas_n_o, // column strobe
  output reg [9:0] eoc_o // end-of-count
);
  reg [1:0] bank_reg = 2'h3;
  reg flag_reg = 1'b0;
  reg early_reg = 1'b0;
  time cs_fall_time = 0;
  wire refresh = !row_n_i && (cs_n_i || early_reg || mode_i == 3'h0 || mode_i == 3'h2);
  initial
  begin
    eoc_o = 10'h07f;
    req_n_o = 1'b1;
  end
  always @(negedge als_i)
  begin
    bank_reg = {bank_hi_i, bank_lo_i};
    if (mode_i == 3'h7)
      eoc_o = (bank_hi_i == bank_lo_i) ? 10'h07f : (bank_lo_i ? 10'h0ff : 10'h1ff);
  end
  always @(posedge rfclk_i)
    if (mode_i == 3'h5)
      flag_reg = 1'b1;
  always @(negedge rfclk_i)
    if (flag_reg)
      req_n_o = 1'b0;
  always @(posedge refresh)
  begin
    flag_reg = 1'b0;
    req_n_o = 1'b1;
  end
  // row request inside the select guard taken as a hidden refresh
  always @(negedge cs_n_i)
    cs_fall_time = $time;
  always @(negedge row_n_i)
    early_reg = (mode_i == 3'h5) && flag_reg && ($time - cs_fall_time < 20);
  always @(posedge row_n_i)
    early_reg = 1'b0;
  always @*
    ras_n_o = refresh ? {4{row_n_i}} : ~({3'h0, !row_n_i && !cs_n_i} << bank_reg);
  assign cas_n_o = !((!row_n_i && !cs_n_i && mode_i[2]) || (mode_i == 3'h6 && !col_n_i));
endmodule // dram_dev_model

// ### test/tb_top.sv
// self-checking bench for the host sequencer against the device model
`timescale 1ns/1ns
module tb_top;
  reg clk_sys_i = 1'b0;
  reg rstn_i = 1'b0;
  reg [3:0] addr_i = 4'h0;
  reg [31:0] wdata_i = 32'h0000_0000;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  wire [31:0] rdata_o;
  wire req_n, cs_n, als, bh, bl, row_n, col_n, rfclk, cas_n;
  wire [2:0] mode;
  wire [3:0] ras_n;
  wire [9:0] eoc;
  integer errors = 0;
  integer compares = 0;
  integer i, n;
  reg [31:0] d, e;
  reg [3:0] m;
  always #10 clk_sys_i = ~clk_sys_i;
  dram_host #(.REFRESH_PERIOD_NS(400)) i_dram_host (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .refresh_req_n_i(req_n), .mode_o(mode), .chip_select_n_o(cs_n),
    .address_latch_strobe_o(als), .bank_select_high_o(bh), .bank_select_low_o(bl),
    .row_strobe_request_in_n_o(row_n), .column_strobe_request_in_n_o(col_n), .refresh_period_clock_o(rfclk));
  dram_dev_model i_dram_dev_model (
    .mode_i(mode), .cs_n_i(cs_n), .als_i(als), .bank_hi_i(bh), .bank_lo_i(bl), .row_n_i(row_n),
    .col_n_i(col_n), .rfclk_i(rfclk), .req_n_o(req_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .eoc_o(eoc));
  task chk(input string name, input [31:0] seen, input [31:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("wrong value %0s expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  task wr(input [3:0] a, input [31:0] v);
  begin
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  end
  endtask
  task rd(input [3:0] a);
  begin
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(posedge clk_sys_i);
    d = rdata_o;
  end
  endtask
  // one command, then gather row strobes and column cycles past the row strobe
  task access(input [31:0] cmd);
  begin
    wr(4'h4, cmd);
    m = 4'h0;
    n = 0;
    repeat (30)
    begin
      @(posedge clk_sys_i);
      m = m | ~ras_n;
      if (!cas_n && &ras_n)
        n = n + 1;
    end
  end
  endtask
  task close_out;
  begin
    $display("compares %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd(4'h0);
    chk("mode", d, 32'h0000_0005);
    rd(4'hc);
    chk("eoc", d, 32'h0000_007f);
    chk("model eoc", eoc, 32'h0000_007f);
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1)
    begin
      access(i);
      chk("row strobes", m, 4'h1 << i);
      chk("extended column", n, 0);
    end
    $display("test bank decode done");
    repeat (40) @(posedge clk_sys_i);
    rd(4'h8);
    chk("refresh request", d[1], 1'b1);
    wr(4'h0, 32'h0000_0006);
    access(32'h0000_0008);
    rd(4'h8);
    chk("refresh request", d[1], 1'b0);
    $display("test refresh done");
    access(32'h0000_0006);
    chk("row strobes", m, 4'h4);
    chk("extended column", n, 3);
    access(32'h0000_0002);
    chk("extended column", n, 0);
    $display("test fast access done");
    wr(4'h0, 32'h0000_0007);
    for (i = 0; i < 4; i = i + 1)
    begin
      access(16 + (i + 3) % 4);
      e = (i == 3) ? 32'h0000_01ff : (i == 2) ? 32'h0000_00ff : 32'h0000_007f;
      rd(4'hc);
      chk("eoc", d, e);
      chk("model eoc", eoc, e);
    end
    wr(4'h0, 32'h0000_0005);
    access(1);
    rd(4'hc);
    chk("eoc", d, 32'h0000_01ff);
    chk("model eoc", eoc, 32'h0000_01ff);
    rd(4'h8);
    chk("refresh count", d[31:16], 1);
    $display("test end of count done");
    close_out;
  end
  initial
  begin
    #200000;
    errors = errors + 1;
    close_out;
  end
endmodule // tb_top
